// ---- src/cfr_pkg.sv ----
// Constants for the CAN receive flag and receive interrupt enable block
//
// Contract
// - Overrun sets flag bit 1; error interrupt pends while set unless masked.
// - Receive-full bit 0 sets only when a good message reaches the foreground slot.
// - While receive-full is set, no FIFO entry moves into the foreground buffer.
// - Receive interrupt pends while receive-full and its enable are both set.
// - Bus-off only when transmit errors exceed 255; receiver state also shows it.
// - Leaving bus-off switches the reported receiver state to OK at once.
// - Eight-bit interrupt enable register at index 0x05, reset value all zeros.
// - Enable register readable anytime, writable only outside initialization mode.
// - Request and acknowledge both set force the enable register bits outside the state enables to reset.
// - Receiver and transmitter state enable bits survive initialization mode.
// - Fixed 64-register window at a system-level base plus offset.
package cfr_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h01;
    localparam logic [5:0] IDX_FLAGS = 6'h04;
    localparam logic [5:0] IDX_IRQ_EN = 6'h05;
    localparam logic [5:0] IDX_RX_DATA = 6'h10;
    localparam int WINDOW_REGS = 64;
    // Field positions shared by flag and enable registers, then the control register bits
    localparam int B_RXF = 0;
    localparam int B_OVR = 1;
    localparam int B_TST_LO = 2;
    localparam int B_TST_HI = 3;
    localparam int B_RST_LO = 4;
    localparam int B_RST_HI = 5;
    localparam int B_CSC = 6;
    localparam int B_WUP = 7;
    localparam int B_INIT_RQ = 0;
    localparam int B_INIT_AK = 1;
    // Bits of the enable register that initialization mode leaves alone
    localparam logic [7:0] IRQ_EN_KEEP_MASK = 8'h3C;
    localparam logic [7:0] IRQ_EN_RESET = 8'h00;
    localparam logic [7:0] FLAGS_W1C_MASK = 8'hC3;
    // Error counter thresholds
    localparam logic [8:0] BUS_OFF_LIMIT = 9'h0FF;
    localparam logic [8:0] WARN_LIMIT = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
    // Reported state codes
    localparam logic [1:0] ST_OK = 2'h0;
    localparam logic [1:0] ST_WARN = 2'h1;
    localparam logic [1:0] ST_PASSIVE = 2'h2;
    localparam logic [1:0] ST_BUS_OFF = 2'h3;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : cfr_pkg

// ---- src/cfr_rx_mem.sv ----
// Storage for the receive FIFO entries behind the foreground buffer
`timescale 1ns/10ps
`default_nettype none
module cfr_rx_mem #(
    parameter int WIDTH = 32,
    parameter int AW = 2
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];

    // Write port; no reset, contents are only read after being written
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge clk)
    begin
        rd_data <= mem[rd_addr];
    end
endmodule : cfr_rx_mem
`default_nettype wire

// ---- src/cfr_rx_flags.sv ----
// Receive flags, receive FIFO front end and receive interrupt enable over AXI4-Lite
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module cfr_rx_flags #(
    parameter int ADDR_W = 12,
    parameter int MSG_W = 32,
    parameter int FIFO_AW = 2
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_msg_valid,
    input wire logic rx_msg_ok,
    input wire logic [MSG_W-1:0] rx_msg_data,
    input wire logic [8:0] rx_err_count,
    input wire logic [8:0] tx_err_count,
    input wire logic wakeup_event,
    input wire logic init_done,
    output logic init_request,
    output logic bus_off,
    output logic rx_irq,
    output logic err_irq,
    output logic irq
);
    localparam int DEPTH = 1 << FIFO_AW;

    logic aw_held_r, w_held_r;
    logic [5:0] aw_idx_r;
    logic aw_in_win_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;
    logic [7:0] flags_r, irq_en_r;
    logic init_ack_r;
    logic [MSG_W-1:0] fg_buf_r, mem_rd_data;
    logic [FIFO_AW-1:0] wr_ptr_r, rd_ptr_r;
    logic [FIFO_AW:0] count_r;
    logic pop_pend_r, push, start_pop, overrun;
    logic [1:0] rx_state_r, tx_state_r, rx_state_nxt, tx_state_nxt;
    logic bus_off_nxt;
    logic [7:0] flags_w1c;

    // Register index decode, shared by read and write paths
    function automatic logic in_window(input logic [ADDR_W-1:0] a);
        return a < ADDR_W'(cfr_pkg::WINDOW_REGS * 4);
    endfunction : in_window

    function automatic logic [5:0] reg_idx(input logic [ADDR_W-1:0] a);
        return a[7:2];
    endfunction : reg_idx

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    // Address and data are taken independently, in either order
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_held_r <= 1'b0;
            aw_idx_r <= 6'h00;
            aw_in_win_r <= 1'b0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r <= 1'b1;
            aw_idx_r <= reg_idx(s_axi_awaddr);
            aw_in_win_r <= in_window(s_axi_awaddr);
        end
        else if (do_write)
        begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
        else if (do_write)
        begin
            w_held_r <= 1'b0;
        end
    end

    // Ready drops once a channel is held, so only one write is in flight
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

    // Response follows both halves; outside the window gives DECERR
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cfr_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= aw_in_win_r ? cfr_pkg::RESP_OKAY : cfr_pkg::RESP_DECERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control: initialization request and acknowledge

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            init_request <= 1'b0;
        end
        else if (do_write && aw_in_win_r && aw_idx_r == cfr_pkg::IDX_CTRL && wstrb_r[0])
        begin
            init_request <= wdata_r[cfr_pkg::B_INIT_RQ];
        end
    end

    // Acknowledge tracks the request once the bit engine reports it is idle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            init_ack_r <= 1'b0;
        end
        else
        begin
            init_ack_r <= init_request ? (init_ack_r || init_done) : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enable register

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_en_r <= cfr_pkg::IRQ_EN_RESET;
        end
        else if (init_request && init_ack_r)
        begin
            // State enables are kept through initialization mode
            irq_en_r <= (irq_en_r & cfr_pkg::IRQ_EN_KEEP_MASK)
                | (cfr_pkg::IRQ_EN_RESET & ~cfr_pkg::IRQ_EN_KEEP_MASK);
        end
        else if (do_write && aw_in_win_r && aw_idx_r == cfr_pkg::IDX_IRQ_EN && wstrb_r[0]
            && !init_request && !init_ack_r)
        begin
            irq_en_r <= wdata_r[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive FIFO and foreground buffer

    assign push = rx_msg_valid && rx_msg_ok && (count_r != (FIFO_AW+1)'(DEPTH));
    assign overrun = rx_msg_valid && rx_msg_ok && (count_r == (FIFO_AW+1)'(DEPTH));
    // No shift while the foreground slot is still owned by the host
    assign start_pop = !flags_r[cfr_pkg::B_RXF] && !pop_pend_r && count_r != '0;

    cfr_rx_mem #(
        .WIDTH(MSG_W),
        .AW(FIFO_AW)
    ) u_mem (
        .clk(clk),
        .wr_en(push),
        .wr_addr(wr_ptr_r),
        .wr_data(rx_msg_data),
        .rd_addr(rd_ptr_r),
        .rd_data(mem_rd_data)
    );

    // Pointers; an entry leaves the count when it lands in the foreground
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            pop_pend_r <= 1'b0;
        end
        else
        begin
            pop_pend_r <= start_pop;
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop_pend_r)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop_pend_r);
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fg_buf_r <= '0;
        end
        else if (pop_pend_r)
        begin
            fg_buf_r <= mem_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error states and bus-off

    always_comb
    begin
        bus_off_nxt = tx_err_count > cfr_pkg::BUS_OFF_LIMIT;
        if (bus_off_nxt)
            tx_state_nxt = cfr_pkg::ST_BUS_OFF;
        else if (tx_err_count > cfr_pkg::PASSIVE_LIMIT)
            tx_state_nxt = cfr_pkg::ST_PASSIVE;
        else if (tx_err_count > cfr_pkg::WARN_LIMIT)
            tx_state_nxt = cfr_pkg::ST_WARN;
        else
            tx_state_nxt = cfr_pkg::ST_OK;
        if (bus_off_nxt)
            rx_state_nxt = cfr_pkg::ST_BUS_OFF;
        else if (bus_off)
            rx_state_nxt = cfr_pkg::ST_OK;
        else if (rx_err_count > cfr_pkg::PASSIVE_LIMIT)
            rx_state_nxt = cfr_pkg::ST_PASSIVE;
        else if (rx_err_count > cfr_pkg::WARN_LIMIT)
            rx_state_nxt = cfr_pkg::ST_WARN;
        else
            rx_state_nxt = cfr_pkg::ST_OK;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_off <= 1'b0;
            rx_state_r <= cfr_pkg::ST_OK;
            tx_state_r <= cfr_pkg::ST_OK;
        end
        else
        begin
            bus_off <= bus_off_nxt;
            rx_state_r <= rx_state_nxt;
            tx_state_r <= tx_state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags and state fields that follow the state each cycle; for a sticky flag a set in the same cycle as a clear wins

    assign flags_w1c = (do_write && aw_in_win_r && aw_idx_r == cfr_pkg::IDX_FLAGS && wstrb_r[0])
        ? (wdata_r[7:0] & cfr_pkg::FLAGS_W1C_MASK) : 8'h00;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flags_r <= 8'h00;
        end
        else
        begin
            flags_r[cfr_pkg::B_RXF] <= pop_pend_r
                || (flags_r[cfr_pkg::B_RXF] && !flags_w1c[cfr_pkg::B_RXF]);
            flags_r[cfr_pkg::B_OVR] <= overrun
                || (flags_r[cfr_pkg::B_OVR] && !flags_w1c[cfr_pkg::B_OVR]);
            flags_r[cfr_pkg::B_WUP] <= wakeup_event
                || (flags_r[cfr_pkg::B_WUP] && !flags_w1c[cfr_pkg::B_WUP]);
            flags_r[cfr_pkg::B_CSC] <= (rx_state_nxt != rx_state_r) || (tx_state_nxt != tx_state_r)
                || (flags_r[cfr_pkg::B_CSC] && !flags_w1c[cfr_pkg::B_CSC]);
            flags_r[cfr_pkg::B_RST_HI:cfr_pkg::B_RST_LO] <= rx_state_nxt;
            flags_r[cfr_pkg::B_TST_HI:cfr_pkg::B_TST_LO] <= tx_state_nxt;
        end
    end

    // Requests are flag AND enable, registered every cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_irq <= 1'b0;
            err_irq <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            rx_irq <= flags_r[cfr_pkg::B_RXF] && irq_en_r[cfr_pkg::B_RXF];
            err_irq <= flags_r[cfr_pkg::B_OVR] && irq_en_r[cfr_pkg::B_OVR];
            irq <= |(flags_r & irq_en_r & cfr_pkg::FLAGS_W1C_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    // One read at a time; data come one cycle after the address
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= cfr_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= in_window(s_axi_araddr) ? cfr_pkg::RESP_OKAY : cfr_pkg::RESP_DECERR;
            if (!in_window(s_axi_araddr))
                s_axi_rdata <= 32'h0000_0000;
            else if (reg_idx(s_axi_araddr) == cfr_pkg::IDX_FLAGS)
                s_axi_rdata <= {24'h000000, flags_r};
            else if (reg_idx(s_axi_araddr) == cfr_pkg::IDX_IRQ_EN)
                s_axi_rdata <= {24'h000000, irq_en_r};
            else if (reg_idx(s_axi_araddr) == cfr_pkg::IDX_CTRL)
                s_axi_rdata <= {30'h00000000, init_ack_r, init_request};
            else if (reg_idx(s_axi_araddr) == cfr_pkg::IDX_RX_DATA)
                s_axi_rdata <= 32'(fg_buf_r);
            else
                s_axi_rdata <= 32'h0000_0000;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
        else
        begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule : cfr_rx_flags
`default_nettype wire

// ---- tb/cfr_rx_flags_props.sv ----
// Port-level checker for the receive flag block
`timescale 1ns/10ps
`default_nettype none
module cfr_rx_flags_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic [8:0] tx_err_count,
    input wire logic init_request,
    input wire logic bus_off,
    input wire logic rx_irq,
    input wire logic err_irq,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////
    // Bus-off tracks the count of the cycle before; skip the edge after reset
    property p_bus_off;
        $past(arst_n) |-> bus_off == ($past(tx_err_count) > cfr_pkg::BUS_OFF_LIMIT);
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus_off wrong");
    // Summary line covers both sources
    property p_irq_or;
        rx_irq || err_irq |-> irq;
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq missing");
    // Requests only drop after a host write or in init mode
    property p_rx_sticky;
        $fell(rx_irq) |-> $past(s_axi_bvalid) || init_request;
    endproperty
    a_rx_sticky: assert property (p_rx_sticky) else $error("rx_irq dropped");
    property p_err_sticky;
        $fell(err_irq) |-> $past(s_axi_bvalid) || init_request;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("err_irq dropped");
    // Reads outside the window answer DECERR with zero data
    property p_rd_decerr;
        s_axi_arvalid && s_axi_arready && s_axi_araddr >= 12'h100
            |=> s_axi_rvalid && s_axi_rresp == cfr_pkg::RESP_DECERR && s_axi_rdata == 32'h0;
    endproperty
    a_rd_decerr: assert property (p_rd_decerr) else $error("window decode");
    // Write answer two edges after both halves are taken
    property p_b_two;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_b_two: assert property (p_b_two) else $error("bvalid late");
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("rvalid late");
    property p_aw_hold;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2];
    endproperty
    a_aw_hold: assert property (p_aw_hold) else $error("awready early");
    c_rx: cover property (rx_irq);
    c_err: cover property (err_irq);
    c_off: cover property (bus_off);
endmodule : cfr_rx_flags_chk
bind cfr_rx_flags cfr_rx_flags_chk #(.ADDR_W(ADDR_W)) chk_u (.*);
`default_nettype wire

// ---- tb/cfr_can_node.sv ----
// Behavioural bit engine: finished messages, error counters, init handshake
`timescale 1ns/10ps
`default_nettype none
module cfr_can_node (
    input wire logic clk,
    input wire logic init_request,
    output logic rx_msg_valid,
    output logic rx_msg_ok,
    output logic [31:0] rx_msg_data,
    output logic [8:0] rx_err_count,
    output logic [8:0] tx_err_count,
    output logic wakeup_event,
    output logic init_done
);
    // Quiet bus at start
    initial
    begin
        rx_msg_valid = 1'b0;
        rx_msg_ok = 1'b0;
        rx_msg_data = 32'h0;
        rx_err_count = 9'h000;
        tx_err_count = 9'h000;
        wakeup_event = 1'b0;
    end
    // Engine confirms init one cycle after the request
    always @(posedge clk)
        init_done <= init_request;
    // Burst of n messages; qualifiers scrambled once released
    task automatic send(input int n, input logic [31:0] d0, input logic ok);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            rx_msg_valid <= 1'b1;
            rx_msg_ok <= ok;
            rx_msg_data <= d0 + 32'(i);
        end
        @(posedge clk);
        rx_msg_valid <= 1'b0;
        rx_msg_ok <= ~ok;
        rx_msg_data <= ~rx_msg_data;
    endtask : send
    task automatic set_cnt(input logic [8:0] t, input logic [8:0] r);
        @(posedge clk);
        tx_err_count <= t;
        rx_err_count <= r;
    endtask : set_cnt
    // One-cycle wake-up pulse from the bus side
    task automatic wake();
        @(posedge clk);
        wakeup_event <= 1'b1;
        @(posedge clk);
        wakeup_event <= 1'b0;
    endtask : wake
endmodule : cfr_can_node
`default_nettype wire

// ---- tb/tb.sv ----
// Register-level testbench for the receive flag block
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [11:0] A_CTL = {4'h0, cfr_pkg::IDX_CTRL, 2'h0};
    localparam logic [11:0] A_FLG = {4'h0, cfr_pkg::IDX_FLAGS, 2'h0};
    localparam logic [11:0] A_EN = {4'h0, cfr_pkg::IDX_IRQ_EN, 2'h0};
    localparam logic [11:0] A_DAT = {4'h0, cfr_pkg::IDX_RX_DATA, 2'h0};
    localparam logic [1:0] DEC = cfr_pkg::RESP_DECERR;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rx_msg_data;
    logic rx_msg_valid, rx_msg_ok, wakeup_event, init_done, init_request;
    logic bus_off, rx_irq, err_irq, irq;
    logic [8:0] rx_err_count, tx_err_count;
    int err_count = 0;
    int samples_checked = 0;
    always #50 clk = ~clk;
    cfr_rx_flags dut_u (.*);
    cfr_can_node node_u (.*);
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Write holds each channel until its own ready
    task automatic wrc(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
    endtask : wrc
    task automatic rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
    endtask : rdc
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////
    // Main sequence; settle waits cover the stated pipeline depths
    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rdc(A_EN, 32'h0);
        rdc(A_FLG, 32'h0);
        rdc(12'h0FC, 32'h0);
        rdc(12'h100, 32'h0, DEC);
        wrc(12'h100, 8'hFF, DEC);
        wrc(A_EN, 8'hFF);
        rdc(A_EN, 32'hFF);
        $display("test map done");
        node_u.send(1, 32'hA00, 1'b0);
        repeat (8) @(posedge clk);
        rdc(A_FLG, 32'h0);
        chk(32'(rx_irq), 32'h0);
        node_u.send(2, 32'hB00, 1'b1);
        repeat (8) @(posedge clk);
        rdc(A_FLG, 32'h1);
        chk(32'({rx_irq, irq}), 32'h3);
        wrc(A_FLG, 8'h00);
        repeat (8) @(posedge clk);
        rdc(A_DAT, 32'hB00);
        wrc(A_FLG, 8'h01);
        repeat (8) @(posedge clk);
        rdc(A_DAT, 32'hB01);
        wrc(A_FLG, 8'h01);
        repeat (8) @(posedge clk);
        rdc(A_FLG, 32'h0);
        chk(32'(rx_irq), 32'h0);
        $display("test receive done");
        // One in front, four waiting, the sixth overruns
        node_u.send(6, 32'hC00, 1'b1);
        repeat (8) @(posedge clk);
        rdc(A_FLG, 32'h3);
        chk(32'(err_irq), 32'h1);
        wrc(A_EN, 8'hFD);
        repeat (3) @(posedge clk);
        chk(32'({err_irq, irq}), 32'h1);
        wrc(A_FLG, 8'h02);
        rdc(A_FLG, 32'h1);
        for (int i = 0; i < 5; i++)
        begin
            rdc(A_DAT, 32'hC00 + 32'(i));
            wrc(A_FLG, 8'h01);
            repeat (8) @(posedge clk);
        end
        rdc(A_FLG, 32'h0);
        $display("test overrun done");
        wrc(A_EN, 8'hFF);
        wrc(A_CTL, 8'h01);
        repeat (8) @(posedge clk);
        rdc(A_CTL, 32'h3);
        rdc(A_EN, 32'h3C);
        wrc(A_EN, 8'h00);
        rdc(A_EN, 32'h3C);
        wrc(A_CTL, 8'h00);
        repeat (8) @(posedge clk);
        wrc(A_EN, 8'h03);
        rdc(A_EN, 32'h03);
        $display("test init done");
        // Wake-up flag feeds the summary line once enabled
        node_u.wake();
        wrc(A_EN, 8'h83);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h1);
        rdc(A_FLG, 32'h80);
        wrc(A_FLG, 8'h80);
        // Receive errors alone move the receiver state to passive
        node_u.set_cnt(9'h000, 9'h080);
        repeat (8) @(posedge clk);
        rdc(A_FLG, 32'h60);
        wrc(A_FLG, 8'h40);
        rdc(A_FLG, 32'h20);
        node_u.set_cnt(9'h100, 9'h000);
        repeat (8) @(posedge clk);
        chk(32'(bus_off), 32'h1);
        rdc(A_FLG, 32'h7C);
        node_u.set_cnt(9'h0FF, 9'h000);
        repeat (8) @(posedge clk);
        chk(32'(bus_off), 32'h0);
        rdc(A_FLG, 32'h48);
        wrc(A_FLG, 8'h40);
        rdc(A_FLG, 32'h08);
        $display("test bus_off done");
        give_verdict();
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire
